// *** src/snsc_regs.sv ***
`timescale 1ns/1ns
module snsc_regs
  import snsc_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic ce,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic frame_busy,
  output snsc_sys_t sys_ctrl,
  output snsc_pll_a_t pll_a_cfg,
  output snsc_pll_b_t pll_b_cfg
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    snsc_state_t st;
    logic [3:0] bitcnt;
    logic [7:0] shreg;
    logic [15:0] sub;
    logic scl_q;
    logic sda_q;
    logic sda_oe;
    logic streaming;
    logic soft_pulse;
    snsc_bank_t bank;
  } snsc_regs_state_t;

  localparam snsc_regs_state_t STATE_RESET = '{
    st: ST_IDLE, bitcnt: 4'h0, shreg: 8'h00, sub: 16'h0000, scl_q: 1'b1, sda_q: 1'b1,
    sda_oe: 1'b0, streaming: 1'b0, soft_pulse: 1'b0, bank: SNSC_RESET};

  snsc_regs_state_t q_r;
  snsc_regs_state_t q_nxt;

  // reserved and unmapped offsets read as zero
  function automatic logic [7:0] rd_byte(input snsc_bank_t b, input logic [15:0] a);
    logic [7:0] v;
    v = 8'h00;
    for (int i = 0; i < SNSC_NREG; i++) begin
      if (SNSC_OFFSET[i] == a) begin
        v = b[i];
      end
    end
    return v;
  endfunction

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    logic rise;
    logic fall;
    logic start_c;
    logic stop_c;
    logic [7:0] rb;
    q_nxt = q_r;
    rise = scl_in & ~q_r.scl_q;
    fall = ~scl_in & q_r.scl_q;
    start_c = scl_in & q_r.scl_q & q_r.sda_q & ~sda_in;
    stop_c = scl_in & q_r.scl_q & ~q_r.sda_q & sda_in;
    rb = 8'h00;
    q_nxt.scl_q = scl_in;
    q_nxt.sda_q = sda_in;
    q_nxt.soft_pulse = 1'b0;

    if (start_c) begin
      q_nxt.st = ST_DEV;
      q_nxt.bitcnt = 4'h0;
      q_nxt.sda_oe = 1'b0;
    end else if (stop_c) begin
      q_nxt.st = ST_IDLE;
      q_nxt.sda_oe = 1'b0;
    end else if (q_r.st != ST_IDLE) begin
      if (rise) begin
        if (q_r.bitcnt < 4'h8) begin
          if (q_r.st != ST_RDATA) begin
            q_nxt.shreg = {q_r.shreg[6:0], sda_in};
          end
          q_nxt.bitcnt = q_r.bitcnt + 4'h1;
        end else if (q_r.st == ST_RDATA && q_r.bitcnt == 4'h8) begin
          if (sda_in) begin
            q_nxt.st = ST_IDLE;
          end else begin
            q_nxt.sub = q_r.sub + 16'h0001;
            q_nxt.bitcnt = 4'h9;
          end
        end
      end else if (fall) begin
        if (q_r.st == ST_RDATA) begin
          if (q_r.bitcnt == 4'h9) begin
            rb = rd_byte(q_r.bank, q_r.sub);
            q_nxt.shreg = rb;
            q_nxt.sda_oe = ~rb[7];
            q_nxt.bitcnt = 4'h0;
          end else if (q_r.bitcnt == 4'h8) begin
            q_nxt.sda_oe = 1'b0;
          end else if (q_r.bitcnt != 4'h0) begin
            q_nxt.shreg = {q_r.shreg[6:0], 1'b0};
            q_nxt.sda_oe = ~q_r.shreg[6];
          end
        end else if (q_r.bitcnt == 4'h9) begin
          q_nxt.sda_oe = 1'b0;
          q_nxt.bitcnt = 4'h0;
        end else if (q_r.bitcnt == 4'h8) begin
          q_nxt.bitcnt = 4'h9;
          q_nxt.sda_oe = 1'b1;
          case (q_r.st)
            ST_DEV: begin
              if (q_r.shreg == SNSC_DEV_WRITE) begin
                q_nxt.st = ST_SUBHI;
              end else if (q_r.shreg == SNSC_DEV_READ) begin
                q_nxt.st = ST_RDATA;
                q_nxt.bitcnt = 4'h9;
              end else begin
                q_nxt.st = ST_IDLE;
                q_nxt.sda_oe = 1'b0;
              end
            end
            ST_SUBHI: begin
              q_nxt.sub[15:8] = q_r.shreg;
              q_nxt.st = ST_SUBLO;
            end
            ST_SUBLO: begin
              q_nxt.sub[7:0] = q_r.shreg;
              q_nxt.st = ST_WDATA;
            end
            ST_WDATA: begin
              q_nxt.sub = q_r.sub + 16'h0001;
              if (q_r.sub == SNSC_SOFT_RESET_OFF && q_r.shreg[SNSC_SOFT_RESET_BIT]) begin
                q_nxt.bank = SNSC_RESET;
                q_nxt.streaming = 1'b0;
                q_nxt.soft_pulse = 1'b1;
              end else begin
                for (int i = 0; i < SNSC_NREG; i++) begin
                  if (SNSC_OFFSET[i] == q_r.sub) begin
                    q_nxt.bank[i] = q_r.shreg & SNSC_WMASK[i];
                  end
                end
              end
            end
            default: begin
              q_nxt.st = ST_IDLE;
              q_nxt.sda_oe = 1'b0;
            end
          endcase
        end
      end
    end

    // a pending standby request takes the mode bit down
    if (q_r.bank[IX_STBY][CTRL_BIT]) begin
      q_nxt.bank[IX_MODE][CTRL_BIT] = 1'b0;
    end
    // streaming starts at once; leaving it waits for the frame unless fast
    // a soft reset wins over a mode bit that is still set in the old bank
    if (q_nxt.soft_pulse) begin
      q_nxt.streaming = 1'b0;
    end else if (q_r.bank[IX_MODE][CTRL_BIT] && !q_r.bank[IX_STBY][CTRL_BIT]) begin
      q_nxt.streaming = 1'b1;
    end else if (q_r.bank[IX_FAST][CTRL_BIT] || !frame_busy) begin
      q_nxt.streaming = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // register
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      q_r <= STATE_RESET;
    end else if (ce) begin
      q_r <= q_nxt;
    end
  end

  // ----------------------------------------------------------------
  // outputs, all slices of flip-flops except sda_out, which is tied to 0
  // ----------------------------------------------------------------
  assign sda_out = 1'b0;
  assign sda_oe = q_r.sda_oe;

  assign sys_ctrl.stream_on = q_r.streaming;
  assign sys_ctrl.standby_truncate = q_r.bank[IX_FAST][CTRL_BIT];
  assign sys_ctrl.standby_request = q_r.bank[IX_STBY][CTRL_BIT];
  assign sys_ctrl.safe_mode = q_r.bank[IX_SAFE][CTRL_BIT];
  assign sys_ctrl.soft_reset_bit = q_r.soft_pulse;
  assign sys_ctrl.slave_id_a = q_r.bank[IX_ID_A];
  assign sys_ctrl.slave_id_b = q_r.bank[IX_ID_B];

  assign pll_a_cfg.pll_a_pre_divide = q_r.bank[IX_A_PRE][2:0];
  assign pll_a_cfg.pll_a_multiplier = {q_r.bank[IX_A_MHI][1:0], q_r.bank[IX_A_MLO]};
  assign pll_a_cfg.pll_a_main_divide = q_r.bank[IX_A_MAIN][3:0];
  assign pll_a_cfg.pll_a_serial_divide = q_r.bank[IX_A_SER][1:0];
  assign pll_a_cfg.pll_a_sys_divide = q_r.bank[IX_A_SYS][1:0];
  assign pll_a_cfg.pll_a_sys_divide_b = q_r.bank[IX_A_SYSB][CTRL_BIT];
  assign pll_a_cfg.pll_a_divider_sync_reset = q_r.bank[IX_A_SYNC][CTRL_BIT];
  assign pll_a_cfg.pll_a_bypass = q_r.bank[IX_A_BYP][CTRL_BIT];
  assign pll_a_cfg.precision = q_r.bank[IX_A_LOOP][LOOP_PREC_LSB +: 2];
  assign pll_a_cfg.ref_count = q_r.bank[IX_A_LOOP][LOOP_REF_LSB +: 2];
  assign pll_a_cfg.pll_a_lock_detect_enable = q_r.bank[IX_A_LOOP][LOOP_LOCK_BIT];
  assign pll_a_cfg.pll_a_charge_pump = q_r.bank[IX_A_LOOP][LOOP_CP_LSB +: 3];
  assign pll_a_cfg.pll_a_predivide_option = q_r.bank[IX_A_OPT][CTRL_BIT];
  assign pll_a_cfg.pll_a_reset_out = q_r.bank[IX_A_RST][CTRL_BIT];

  assign pll_b_cfg.pll_b_pre_divide = q_r.bank[IX_B_PRE][2:0];
  assign pll_b_cfg.pll_b_multiplier = {q_r.bank[IX_B_MHI][1:0], q_r.bank[IX_B_MLO]};
  assign pll_b_cfg.pll_b_sys_divide = q_r.bank[IX_B_SYS][2:0];
  assign pll_b_cfg.sys_divide_b = q_r.bank[IX_B_SYSB][3:0];
  assign pll_b_cfg.pll_b_sampler_divide = q_r.bank[IX_B_SAMP][3:0];
  assign pll_b_cfg.pll_b_converter_divide = q_r.bank[IX_B_CONV][3:0];
  assign pll_b_cfg.pll_b_bypass = q_r.bank[IX_B_BYP][CTRL_BIT];
  assign pll_b_cfg.precision = q_r.bank[IX_B_LOOP][LOOP_PREC_LSB +: 2];
  assign pll_b_cfg.ref_count = q_r.bank[IX_B_LOOP][LOOP_REF_LSB +: 2];
  assign pll_b_cfg.pll_b_lock_detect_enable = q_r.bank[IX_B_LOOP][LOOP_LOCK_BIT];
  assign pll_b_cfg.pll_b_charge_pump = q_r.bank[IX_B_LOOP][LOOP_CP_LSB +: 3];
  assign pll_b_cfg.predivide_option = q_r.bank[IX_B_OPT][CTRL_BIT];
  assign pll_b_cfg.divider_sync_reset = q_r.bank[IX_B_SYNC][CTRL_BIT];
  assign pll_b_cfg.pll_b_reset_out = q_r.bank[IX_B_RST][CTRL_BIT];

endmodule // snsc_regs

// *** src/snsc_pkg.sv ***
package snsc_pkg;

  // ----------------------------------------------------------------
  // serial control bus
  // ----------------------------------------------------------------
  localparam logic [7:0] SNSC_DEV_WRITE = 8'hC0;
  localparam logic [7:0] SNSC_DEV_READ = 8'hC1;

  // ----------------------------------------------------------------
  // register map: index, offset, reset value, writable bits
  // ----------------------------------------------------------------
  localparam int SNSC_NREG = 30;
  localparam logic [15:0] SNSC_SOFT_RESET_OFF = 16'h0103;
  localparam int SNSC_SOFT_RESET_BIT = 0;

  localparam int IX_MODE = 0;
  localparam int IX_FAST = 1;
  localparam int IX_ID_A = 2;
  localparam int IX_ID_B = 3;
  localparam int IX_STBY = 4;
  localparam int IX_SAFE = 5;
  localparam int IX_A_PRE = 6;
  localparam int IX_A_MHI = 7;
  localparam int IX_A_MLO = 8;
  localparam int IX_A_MAIN = 9;
  localparam int IX_A_SER = 10;
  localparam int IX_A_SYS = 11;
  localparam int IX_A_SYSB = 12;
  localparam int IX_A_SYNC = 13;
  localparam int IX_A_BYP = 14;
  localparam int IX_A_LOOP = 15;
  localparam int IX_A_OPT = 16;
  localparam int IX_B_PRE = 17;
  localparam int IX_B_MHI = 18;
  localparam int IX_B_MLO = 19;
  localparam int IX_B_SYS = 20;
  localparam int IX_B_SYSB = 21;
  localparam int IX_B_LOOP = 22;
  localparam int IX_B_BYP = 23;
  localparam int IX_B_SAMP = 24;
  localparam int IX_B_CONV = 25;
  localparam int IX_B_OPT = 26;
  localparam int IX_B_SYNC = 27;
  localparam int IX_A_RST = 28;
  localparam int IX_B_RST = 29;

  typedef logic [SNSC_NREG-1:0][7:0] snsc_bank_t;
  typedef logic [SNSC_NREG-1:0][15:0] snsc_offs_t;

  // the list opens with the highest index so that entry i sits at index i
  localparam snsc_offs_t SNSC_OFFSET = {
    16'h0319, 16'h0318, 16'h0315, 16'h0314, 16'h0313, 16'h0312, 16'h0311, 16'h0310,
    16'h030F, 16'h030E, 16'h030D, 16'h030C, 16'h030B, 16'h030A, 16'h0309, 16'h0308,
    16'h0307, 16'h0306, 16'h0305, 16'h0304, 16'h0303, 16'h0302, 16'h0301, 16'h0300,
    16'h010C, 16'h010B, 16'h0109, 16'h0107, 16'h0106, 16'h0100};
  localparam snsc_bank_t SNSC_RESET = {
    8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h08, 8'h00, 8'h09,
    8'h02, 8'h04, 8'h5A, 8'h00, 8'h04, 8'h00, 8'h09, 8'h00,
    8'h00, 8'h01, 8'h02, 8'h03, 8'h00, 8'h32, 8'h00, 8'h01,
    8'h00, 8'h00, 8'hC0, 8'h20, 8'h01, 8'h00};
  localparam snsc_bank_t SNSC_WMASK = {
    8'h01, 8'h01, 8'h01, 8'h01, 8'h0F, 8'h0F, 8'h01, 8'hFF,
    8'h0F, 8'h07, 8'hFF, 8'h03, 8'h07, 8'h01, 8'hFF, 8'h01,
    8'h01, 8'h01, 8'h03, 8'h03, 8'h0F, 8'hFF, 8'h03, 8'h07,
    8'h01, 8'h01, 8'hFF, 8'hFF, 8'h01, 8'h01};

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int LOOP_PREC_LSB = 6;
  localparam int LOOP_REF_LSB = 4;
  localparam int LOOP_LOCK_BIT = 3;
  localparam int LOOP_CP_LSB = 0;
  localparam int CTRL_BIT = 0;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [2:0] pll_a_pre_divide;
    logic [9:0] pll_a_multiplier;
    logic [3:0] pll_a_main_divide;
    logic [1:0] pll_a_serial_divide;
    logic [1:0] pll_a_sys_divide;
    logic pll_a_sys_divide_b;
    logic pll_a_divider_sync_reset;
    logic pll_a_bypass;
    logic [1:0] precision;
    logic [1:0] ref_count;
    logic pll_a_lock_detect_enable;
    logic [2:0] pll_a_charge_pump;
    logic pll_a_predivide_option;
    logic pll_a_reset_out;
  } snsc_pll_a_t;

  typedef struct packed {
    logic [2:0] pll_b_pre_divide;
    logic [9:0] pll_b_multiplier;
    logic [2:0] pll_b_sys_divide;
    logic [3:0] sys_divide_b;
    logic [3:0] pll_b_sampler_divide;
    logic [3:0] pll_b_converter_divide;
    logic pll_b_bypass;
    logic [1:0] precision;
    logic [1:0] ref_count;
    logic pll_b_lock_detect_enable;
    logic [2:0] pll_b_charge_pump;
    logic predivide_option;
    logic divider_sync_reset;
    logic pll_b_reset_out;
  } snsc_pll_b_t;

  typedef struct packed {
    logic stream_on;
    logic standby_truncate;
    logic standby_request;
    logic safe_mode;
    logic soft_reset_bit;
    logic [7:0] slave_id_a;
    logic [7:0] slave_id_b;
  } snsc_sys_t;

  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_DEV = 6'h02,
    ST_SUBHI = 6'h04,
    ST_SUBLO = 6'h08,
    ST_WDATA = 6'h10,
    ST_RDATA = 6'h20
  } snsc_state_t;

endpackage

// *** bench/snsc_regs_monitor.sv ***
`timescale 1ns/1ns
module snsc_regs_monitor
  import snsc_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic ce,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe,
  input wire logic frame_busy,
  input wire snsc_sys_t sys_ctrl,
  input wire snsc_pll_a_t pll_a_cfg,
  input wire snsc_pll_b_t pll_b_cfg
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);

  sequence s_scl_fell;
    $past(scl_in, 2) && !$past(scl_in);
  endsequence

  a_pin_low: assert property (sda_out == 1'h0)
    else $error("sda_out driven high");
  a_oe_after_fall: assert property ($changed(sda_oe) |-> s_scl_fell)
    else $error("sda_oe moved away from a scl fall");
  a_reset_sys: assert property (disable iff (1'h0) reset |=> !sda_oe && !sys_ctrl.stream_on
    && sys_ctrl.standby_truncate && !sys_ctrl.safe_mode) else $error("system defaults wrong");
  a_reset_pll: assert property (disable iff (1'h0) reset |=> pll_a_cfg.pll_a_multiplier == 10'h032
    && pll_b_cfg.pll_b_multiplier == 10'h05A && !pll_a_cfg.pll_a_bypass && !pll_b_cfg.pll_b_reset_out
    && pll_a_cfg.pll_a_charge_pump == 3'h1 && pll_b_cfg.pll_b_lock_detect_enable) else $error("pll defaults wrong");
  a_rise_no_request: assert property ($rose(sys_ctrl.stream_on) |-> !$past(sys_ctrl.standby_request))
    else $error("streaming started under standby request");
  a_frame_completes: assert property (sys_ctrl.stream_on && frame_busy && !sys_ctrl.standby_truncate
    && !sys_ctrl.soft_reset_bit |=> sys_ctrl.stream_on || sys_ctrl.soft_reset_bit) else $error("frame cut short");
  a_soft_pulse: assert property (sys_ctrl.soft_reset_bit |=> !sys_ctrl.soft_reset_bit)
    else $error("soft reset pulse too long");
  a_soft_reload: assert property (sys_ctrl.soft_reset_bit |-> (!sys_ctrl.stream_on
    && pll_a_cfg.pll_a_multiplier == 10'h032 && pll_b_cfg.pll_b_multiplier == 10'h05A)) else $error("no reload");
endmodule // snsc_regs_monitor

bind snsc_regs snsc_regs_monitor u_mon (.clk(clk), .reset(reset), .ce(ce), .scl_in(scl_in), .sda_in(sda_in),
  .sda_out(sda_out), .sda_oe(sda_oe), .frame_busy(frame_busy), .sys_ctrl(sys_ctrl), .pll_a_cfg(pll_a_cfg),
  .pll_b_cfg(pll_b_cfg));

// *** bench/snsc_host.sv ***
`timescale 1ns/1ns
// host on the two-wire bus; sda is open drain, released means pulled up
module snsc_host
  import snsc_pkg::*;
(
  input wire logic clk,
  input wire logic sda_w,
  output logic scl,
  output logic sda_low
);
  initial begin
    scl = 1'h1;
    sda_low = 1'h0;
  end
  // three clocks per phase keeps scl above the two-sample minimum
  task hold;
    repeat (3) @(negedge clk);
  endtask
  task start;
    sda_low = 1'h0;
    hold;
    scl = 1'h1;
    hold;
    sda_low = 1'h1;
    hold;
    scl = 1'h0;
    hold;
  endtask
  task stop;
    sda_low = 1'h1;
    hold;
    scl = 1'h1;
    hold;
    sda_low = 1'h0;
    hold;
  endtask
  task bit_io(input logic b, output logic r);
    sda_low = !b;
    hold;
    scl = 1'h1;
    hold;
    r = sda_w;
    scl = 1'h0;
    hold;
  endtask
  task byte_io(input logic [7:0] d, input logic a_in, output logic [7:0] q, output logic a_out);
    for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]);
    bit_io(a_in, a_out);
  endtask
  task probe(input logic [7:0] dev, output logic nack);
    logic [7:0] q;
    start;
    byte_io(dev, 1'h1, q, nack);
    stop;
  endtask
  task head(input logic [15:0] sub, output logic nack);
    logic [7:0] q;
    logic n0, n1, n2;
    start;
    byte_io(SNSC_DEV_WRITE, 1'h1, q, n0);
    byte_io(sub[15:8], 1'h1, q, n1);
    byte_io(sub[7:0], 1'h1, q, n2);
    nack = n0 | n1 | n2;
  endtask
  task wr(input logic [15:0] sub, input logic [7:0] d [32], input int n, output logic nack);
    logic [7:0] q;
    logic a;
    head(sub, nack);
    for (int i = 0; i < n; i++) begin
      byte_io(d[i], 1'h1, q, a);
      nack = nack | a;
    end
    stop;
  endtask
  task rd(input logic [15:0] sub, output logic [7:0] d [32], input int n, output logic nack);
    logic [7:0] q;
    logic a;
    head(sub, nack);
    start;
    byte_io(SNSC_DEV_READ, 1'h1, q, a);
    nack = nack | a;
    for (int i = 0; i < n; i++) byte_io(8'hFF, 1'(i == n - 1), d[i], a);
    stop;
  endtask
endmodule // snsc_host

// *** bench/test_sensor_system_pll_config_regs.sv ***
`timescale 1ns/1ns
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin fail_count++; \
  $display("wrong value at %0t: got %h expected %h", $time, (a), (e)); end end
module test_sensor_system_pll_config_regs;
  import snsc_pkg::*;
  logic clk, reset, ce, frame_busy, scl, host_low, sda_out, sda_oe, nk;
  wire sda_w = !(host_low || (sda_oe && !sda_out));
  snsc_sys_t sys_ctrl;
  snsc_pll_a_t pll_a_cfg;
  snsc_pll_b_t pll_b_cfg;
  int fail_count, cmp_count, seed, i;
  logic [7:0] wd [32];
  logic [7:0] rdv [32];

  snsc_regs u_snsc_regs (.clk(clk), .reset(reset), .ce(ce), .scl_in(scl), .sda_in(sda_w), .sda_out(sda_out),
    .sda_oe(sda_oe), .frame_busy(frame_busy), .sys_ctrl(sys_ctrl), .pll_a_cfg(pll_a_cfg), .pll_b_cfg(pll_b_cfg));
  snsc_host host (.clk(clk), .sda_w(sda_w), .scl(scl), .sda_low(host_low));

  // unmapped offsets give reset 0 and mask 0
  function logic [7:0] exp_rst(input logic [15:0] off, input logic want_mask);
    exp_rst = 8'h00;
    for (int k = 0; k < SNSC_NREG; k++)
      if (SNSC_OFFSET[k] == off) exp_rst = want_mask ? SNSC_WMASK[k] : SNSC_RESET[k];
  endfunction
  // wd[i] was written to offset 0x0300 + i
  function automatic snsc_pll_a_t exp_a();
    exp_a = '{wd[0][2:0], {wd[1][1:0], wd[2]}, wd[3][3:0], wd[4][1:0], wd[5][1:0], wd[6][0], wd[7][0],
      wd[8][0], wd[9][7:6], wd[9][5:4], wd[9][3], wd[9][2:0], wd[10][0], wd[24][0]};
  endfunction
  function automatic snsc_pll_b_t exp_b();
    exp_b = '{wd[11][2:0], {wd[12][1:0], wd[13]}, wd[14][2:0], wd[15][3:0], wd[18][3:0], wd[19][3:0],
      wd[17][0], wd[16][7:6], wd[16][5:4], wd[16][3], wd[16][2:0], wd[20][0], wd[21][0], wd[25][0]};
  endfunction
  task test_done;
    $display("mismatches %0d, comparisons %0d", fail_count, cmp_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task wr1(input logic [15:0] a, input logic [7:0] v);
    wd[0] = v;
    host.wr(a, wd, 1, nk);
    `CHK(nk, 1'h0)
  endtask
  task wait_stream(input logic v);
    int k;
    for (k = 0; k < 20 && sys_ctrl.stream_on !== v; k++) @(negedge clk);
    `CHK(sys_ctrl.stream_on, v)
    if (k == 20) test_done;
  endtask

  initial begin
    clk = 1'h0;
    forever #10 clk = ~clk;
  end

  initial begin
    seed = 32'h6d49;
    reset = 1'h1;
    ce = 1'h1;
    frame_busy = 1'h0;
    repeat (3) @(negedge clk);
    reset = 1'h0;
    repeat (2) @(negedge clk);
    // one burst across the pll range, reserved holes included
    host.rd(16'h0300, rdv, 26, nk);
    `CHK(nk, 1'h0)
    for (i = 0; i < 26; i++) `CHK(rdv[i], exp_rst(16'h0300 + 16'(i), 1'h0))
    for (i = 0; i < 26; i++) wd[i] = 8'($random(seed));
    host.wr(16'h0300, wd, 26, nk);
    `CHK(nk, 1'h0)
    host.rd(16'h0300, rdv, 26, nk);
    `CHK(nk, 1'h0)
    for (i = 0; i < 26; i++) `CHK(rdv[i], wd[i] & exp_rst(16'h0300 + 16'(i), 1'h1))
    `CHK(pll_a_cfg.pll_a_multiplier, {wd[1][1:0], wd[2]})
    `CHK(pll_a_cfg.pll_a_main_divide, wd[3][3:0])
    `CHK(pll_a_cfg.pll_a_divider_sync_reset, wd[7][0])
    `CHK(pll_a_cfg.pll_a_bypass, wd[8][0])
    `CHK({pll_a_cfg.precision, pll_a_cfg.pll_a_lock_detect_enable}, {wd[9][7:6], wd[9][3]})
    `CHK(pll_a_cfg.pll_a_predivide_option, wd[10][0])
    `CHK(pll_b_cfg.pll_b_multiplier, {wd[12][1:0], wd[13]})
    `CHK(pll_b_cfg.pll_b_charge_pump, wd[16][2:0])
    `CHK(pll_b_cfg.pll_b_bypass, wd[17][0])
    `CHK(pll_b_cfg.pll_b_converter_divide, wd[19][3:0])
    `CHK({pll_a_cfg.pll_a_reset_out, pll_b_cfg.pll_b_reset_out}, {wd[24][0], wd[25][0]})
    `CHK(pll_a_cfg, exp_a())
    `CHK(pll_b_cfg, exp_b())
    host.probe(8'hC2, nk);
    `CHK(nk, 1'h1)
    ce = 1'h0;
    repeat (4) @(negedge clk);
    // a frozen device must not answer even its own address
    host.probe(SNSC_DEV_WRITE, nk);
    `CHK(nk, 1'h1)
    ce = 1'h1;
    wr1(16'h0106, 8'h00);
    frame_busy = 1'h1;
    wr1(16'h0100, 8'h01);
    wait_stream(1'h1);
    wr1(16'h0100, 8'h00);
    `CHK(sys_ctrl.stream_on, 1'h1)
    frame_busy = 1'h0;
    wait_stream(1'h0);
    wr1(16'h010B, 8'h01);
    wr1(16'h0100, 8'h01);
    `CHK({sys_ctrl.stream_on, sys_ctrl.standby_request}, 2'h1)
    wr1(16'h010B, 8'h00);
    wr1(16'h0106, 8'h01);
    wr1(16'h0100, 8'h01);
    wait_stream(1'h1);
    frame_busy = 1'h1;
    wr1(16'h0100, 8'h00);
    wait_stream(1'h0);
    wr1(16'h010C, 8'h01);
    `CHK(sys_ctrl.safe_mode, 1'h1)
    wr1(16'h0100, 8'h01);
    wait_stream(1'h1);
    wr1(16'h0107, 8'h5C);
    `CHK(sys_ctrl.slave_id_a, 8'h5C)
    wr1(16'h0103, 8'hFE);
    `CHK(sys_ctrl.stream_on, 1'h1)
    wr1(16'h0103, 8'h01);
    `CHK({sys_ctrl.stream_on, sys_ctrl.safe_mode, pll_a_cfg.pll_a_multiplier}, 12'h032)
    `CHK({sys_ctrl.slave_id_a, sys_ctrl.slave_id_b, sys_ctrl.standby_truncate}, {SNSC_RESET[IX_ID_A], SNSC_RESET[IX_ID_B], SNSC_RESET[IX_FAST][0]})
    host.rd(16'h0103, rdv, 1, nk);
    `CHK(nk, 1'h0)
    `CHK(rdv[0], 8'h00)
    reset = 1'h1;
    repeat (3) @(negedge clk);
    reset = 1'h0;
    repeat (2) @(negedge clk);
    `CHK(pll_b_cfg.pll_b_multiplier, 10'h05A)
    test_done;
  end
endmodule // test_sensor_system_pll_config_regs
